//--- core/css_clock_select.sv
// Clock source select control: select registers, write protection,
// glitch-free source choice per consumer, switch failure and interrupt.
// Assumes source stable flags arrive asynchronously from the oscillators.
module css_clock_select (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Register port
  input  wire logic [11:0]      i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  // Source status, straps and tick timer control
  input  wire logic [4:0]       i_source_stable,
  input  wire logic [2:0]       i_boot_oscillator_config,
  input  wire logic             i_tick_timer_control_bit2,
  // Selected sources and protection state
  output css_pkg::css_src_t     o_bus_clock_source,
  output css_pkg::css_src_t     o_tick_clock_source,
  output css_pkg::css_src_t     o_pwm_pair_a_clock_source,
  output css_pkg::css_src_t     o_pwm_pair_b_clock_source,
  output css_pkg::css_src_t     o_uart_clock_source,
  output css_pkg::css_src_t     o_timer_three_clock_source,
  output logic                  o_protect_open,
  // Interrupt
  output logic                  o_irq
);
  import css_pkg::*;

  typedef struct packed {
    logic [4:0]  stb_s1;
    logic [4:0]  stb_s2;
    logic [4:0]  stb_s3;
    logic [4:0]  stb;
    css_lock_t   lock;
    logic [2:0]  bus_sel;
    logic [2:0]  tick_clock_select;
    logic [31:0] periph;
    logic        switch_failure_flag;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    css_src_t    bus_src;
    css_src_t    tick_src;
    css_src_t    tick_out;
    css_src_t    pwm_a_src;
    css_src_t    pwm_b_src;
    css_src_t    uart_src;
    css_src_t    tmr3_src;
    logic [31:0] rdata;
  } css_state_t;

  css_state_t state_reg;
  css_state_t state_next;

  function automatic css_src_t dec_bus(input logic [2:0] c);
    unique case (c)
      3'h0:    return CSS_SRC_HXT;
      3'h1:    return CSS_SRC_LXT;
      3'h2:    return CSS_SRC_PLL;
      3'h3:    return CSS_SRC_LIRC;
      3'h7:    return CSS_SRC_HIRC;
      default: return CSS_SRC_NONE;
    endcase
  endfunction

  function automatic css_src_t dec_tick(input logic [2:0] c);
    unique case (c)
      3'h0:    return CSS_SRC_HXT;
      3'h1:    return CSS_SRC_LXT;
      3'h2:    return CSS_SRC_HXT_D2;
      3'h3:    return CSS_SRC_BUS_D2;
      3'h7:    return CSS_SRC_HIRC_D2;
      default: return CSS_SRC_NONE;
    endcase
  endfunction

  function automatic css_src_t dec_tmr3(input logic [2:0] c);
    unique case (c)
      3'h0:    return CSS_SRC_HXT;
      3'h1:    return CSS_SRC_LXT;
      3'h2:    return CSS_SRC_BUS;
      3'h7:    return CSS_SRC_HIRC;
      default: return CSS_SRC_NONE;
    endcase
  endfunction

  function automatic css_src_t dec_pwm(input logic [1:0] c);
    unique case (c)
      2'h0: return CSS_SRC_HXT;
      2'h1: return CSS_SRC_LXT;
      2'h2: return CSS_SRC_BUS;
      2'h3: return CSS_SRC_HIRC;
    endcase
  endfunction

  function automatic css_src_t dec_uart(input logic [1:0] c);
    unique case (c)
      2'h0:    return CSS_SRC_HXT;
      2'h1:    return CSS_SRC_PLL;
      2'h3:    return CSS_SRC_HIRC;
      default: return CSS_SRC_NONE;
    endcase
  endfunction

  // Derived sources run whenever their parent runs; the bus clock always runs
  function automatic logic src_ok(input css_src_t s, input logic [4:0] stb);
    unique case (s)
      CSS_SRC_HXT, CSS_SRC_HXT_D2:   return stb[STB_HXT];
      CSS_SRC_LXT:                   return stb[STB_LXT];
      CSS_SRC_PLL:                   return stb[STB_PLL];
      CSS_SRC_LIRC:                  return stb[STB_LIRC];
      CSS_SRC_HIRC, CSS_SRC_HIRC_D2: return stb[STB_HIRC];
      CSS_SRC_BUS, CSS_SRC_BUS_D2:   return 1'b1;
      default:                       return 1'b0;
    endcase
  endfunction

  // Hold the running source until the target is stable; unlisted codes never switch
  function automatic css_src_t follow(input css_src_t cur, input css_src_t tgt, input logic [4:0] stb);
    return src_ok(tgt, stb) ? tgt : cur;
  endfunction

  logic       wr_core;
  logic       wr_prot;
  logic       is_open;
  css_src_t   bus_target;
  css_src_t   tick_target;
  css_src_t   tick_keep;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  always_comb begin
    wr_core     = i_wr && (i_addr == OFS_CORE_SELECT);
    wr_prot     = i_wr && (i_addr == OFS_WRITE_PROTECT);
    is_open     = (state_reg.lock == CSS_OPEN);
    bus_target  = dec_bus(i_wdata[BUS_SEL_LSB +: 3]);
    tick_target = dec_tick(state_reg.tick_clock_select);
    irq_set     = 2'h0;
    irq_clr     = 2'h0;
    state_next  = state_reg;

    // Three-stage sync; a level counts once stages two and three agree
    state_next.stb_s1 = i_source_stable;
    state_next.stb_s2 = state_reg.stb_s1;
    state_next.stb_s3 = state_reg.stb_s2;
    if (state_reg.stb_s2 == state_reg.stb_s3) begin
      state_next.stb = state_reg.stb_s3;
    end

    if (wr_prot) begin
      unique case (state_reg.lock)
        CSS_LOCKED: state_next.lock = (i_wdata[7:0] == UNLOCK_KEY1) ? CSS_KEY1 : CSS_LOCKED;
        CSS_KEY1:   state_next.lock = (i_wdata[7:0] == UNLOCK_KEY2) ? CSS_KEY2 : CSS_LOCKED;
        CSS_KEY2:   state_next.lock = (i_wdata[7:0] == UNLOCK_KEY3) ? CSS_OPEN : CSS_LOCKED;
        // Any further write re-arms protection
        CSS_OPEN:   state_next.lock = CSS_LOCKED;
        default:    state_next.lock = CSS_LOCKED;
      endcase
    end

    if (wr_core) begin
      if (is_open) begin
        state_next.bus_sel           = i_wdata[BUS_SEL_LSB +: 3];
        state_next.tick_clock_select = i_wdata[TICK_SEL_LSB +: 3];
        state_next.switch_failure_flag = !src_ok(bus_target, state_reg.stb);
        irq_set[IRQ_SW_FAIL] = !src_ok(bus_target, state_reg.stb);
      end else begin
        irq_set[IRQ_LOCKED] = 1'b1;
      end
    end else if (i_wr && (i_addr == OFS_CLOCK_STATUS) && i_wdata[SW_FAIL_BIT]) begin
      state_next.switch_failure_flag = 1'b0;
    end

    if (i_wr && (i_addr == OFS_PERIPH_SELECT)) begin
      state_next.periph = i_wdata | PERIPH_RSVD_MASK;
    end
    if (i_wr && (i_addr == OFS_IRQ_ENABLE)) begin
      state_next.irq_enable = i_wdata[1:0];
    end
    if (i_wr && (i_addr == OFS_IRQ_CLEAR)) begin
      irq_clr = i_wdata[1:0];
    end
    // Set beats clear in the same cycle
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;

    state_next.bus_src   = follow(state_reg.bus_src, dec_bus(state_reg.bus_sel), state_reg.stb);
    // Keep tracking while the timer runs on its own clock, so a defined source is never lost
    tick_keep            = follow(state_reg.tick_src, tick_target, state_reg.stb);
    state_next.tick_src  = tick_keep;
    state_next.tick_out  = i_tick_timer_control_bit2 ? CSS_SRC_NONE : tick_keep;
    state_next.pwm_a_src = follow(state_reg.pwm_a_src, dec_pwm(state_reg.periph[PWM_A_LSB +: 2]), state_reg.stb);
    state_next.pwm_b_src = follow(state_reg.pwm_b_src, dec_pwm(state_reg.periph[PWM_B_LSB +: 2]), state_reg.stb);
    state_next.uart_src  = follow(state_reg.uart_src, dec_uart(state_reg.periph[UART_LSB +: 2]), state_reg.stb);
    state_next.tmr3_src  = follow(state_reg.tmr3_src, dec_tmr3(state_reg.periph[TMR3_LSB +: 3]), state_reg.stb);

    state_next.rdata = 32'h00000000;
    if (i_rd) begin
      unique case (i_addr)
        OFS_CLOCK_STATUS:  state_next.rdata = {24'h000000, state_reg.switch_failure_flag, 2'h0, state_reg.stb};
        OFS_CORE_SELECT:   state_next.rdata = {26'h0000000, state_reg.tick_clock_select, state_reg.bus_sel};
        OFS_PERIPH_SELECT: state_next.rdata = state_reg.periph;
        OFS_IRQ_STATUS:    state_next.rdata = {30'h00000000, state_reg.irq_status};
        OFS_IRQ_ENABLE:    state_next.rdata = {30'h00000000, state_reg.irq_enable};
        OFS_WRITE_PROTECT: state_next.rdata = {31'h00000000, is_open};
        default:           state_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg                   <= '0;
      state_reg.lock              <= CSS_LOCKED;
      state_reg.bus_sel           <= i_boot_oscillator_config;
      state_reg.tick_clock_select <= RST_TICK_SELECT;
      state_reg.periph            <= RST_PERIPH_SELECT;
      // Boot source assumed running so the core clock is never lost
      state_reg.bus_src           <= dec_bus(i_boot_oscillator_config);
      state_reg.tick_src          <= CSS_SRC_NONE;
      state_reg.tick_out          <= CSS_SRC_NONE;
      state_reg.pwm_a_src         <= CSS_SRC_HIRC;
      state_reg.pwm_b_src         <= CSS_SRC_HIRC;
      state_reg.uart_src          <= CSS_SRC_HIRC;
      state_reg.tmr3_src          <= CSS_SRC_HIRC;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata                    = state_reg.rdata;
  assign o_bus_clock_source         = state_reg.bus_src;
  assign o_tick_clock_source        = state_reg.tick_out;
  assign o_pwm_pair_a_clock_source  = state_reg.pwm_a_src;
  assign o_pwm_pair_b_clock_source  = state_reg.pwm_b_src;
  assign o_uart_clock_source        = state_reg.uart_src;
  assign o_timer_three_clock_source = state_reg.tmr3_src;
  assign o_protect_open             = (state_reg.lock == CSS_OPEN);
  assign o_irq                      = |(state_reg.irq_status & state_reg.irq_enable);
endmodule

//--- core/css_pkg.sv
// Constants, types and register map of the clock source select block.
// Assumes one 125 MHz clock and a plain address/strobe register port.
// Function
// - Tick field bits 5:3 picks crystal, slow crystal, crystal/2, bus/2 or fast oscillator/2.
// - Tick selection applies only while tick timer control bit 2 is zero.
// - Bus and tick fields ignore writes until 59h, 16h, 88h unlock protection.
// - Bus field bits 2:0 picks crystal, slow crystal, PLL, 10 kHz or fast oscillator.
// - Every reset reloads the bus field from the boot oscillator configuration.
// - Bits 31:30 pick the shared clock of PWM pair two and three.
// - Bits 29:28 pick the shared clock of PWM pair zero and one.
// - Bits 25:24 pick the UART clock: crystal, PLL or fast oscillator.
// - Bits 22:20 pick the timer three clock; 000 is the fast crystal.
// - Timer three codes 001, 010, 111: slow crystal, bus clock, fast oscillator.
// - A bus switch sets failure flag if target unstable, clears it otherwise; write 1 clears.
package css_pkg;
  // Register offsets
  localparam logic [11:0] OFS_CLOCK_STATUS   = 12'h00C;
  localparam logic [11:0] OFS_CORE_SELECT    = 12'h010;
  localparam logic [11:0] OFS_PERIPH_SELECT  = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS     = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLEAR      = 12'h01C;
  localparam logic [11:0] OFS_IRQ_ENABLE     = 12'h020;
  localparam logic [11:0] OFS_WRITE_PROTECT  = 12'h100;
  // Reset values
  localparam logic [2:0]  RST_TICK_SELECT    = 3'h7;
  localparam logic [31:0] RST_PERIPH_SELECT  = 32'hFFFFFFFF;
  // Reserved bits of the peripheral select word, held at one
  localparam logic [31:0] PERIPH_RSVD_MASK   = 32'h0C8888F0;
  // Field positions
  localparam int BUS_SEL_LSB   = 0;
  localparam int TICK_SEL_LSB  = 3;
  localparam int PWM_B_LSB     = 30;
  localparam int PWM_A_LSB     = 28;
  localparam int UART_LSB      = 24;
  localparam int TMR3_LSB      = 20;
  localparam int SW_FAIL_BIT   = 7;
  localparam int TICK_OWN_BIT  = 2;
  // Unlock sequence
  localparam logic [7:0] UNLOCK_KEY1 = 8'h59;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h16;
  localparam logic [7:0] UNLOCK_KEY3 = 8'h88;
  // Source stable flag positions
  localparam int STB_HXT  = 0;
  localparam int STB_LXT  = 1;
  localparam int STB_PLL  = 2;
  localparam int STB_LIRC = 3;
  localparam int STB_HIRC = 4;
  // Interrupt event bits
  localparam int IRQ_SW_FAIL = 0;
  localparam int IRQ_LOCKED  = 1;

  typedef enum logic [3:0] {
    CSS_SRC_HXT     = 4'h0,
    CSS_SRC_LXT     = 4'h1,
    CSS_SRC_PLL     = 4'h2,
    CSS_SRC_LIRC    = 4'h3,
    CSS_SRC_HIRC    = 4'h4,
    CSS_SRC_HXT_D2  = 4'h5,
    CSS_SRC_BUS_D2  = 4'h6,
    CSS_SRC_HIRC_D2 = 4'h7,
    CSS_SRC_BUS     = 4'h8,
    CSS_SRC_NONE    = 4'hF
  } css_src_t;

  typedef enum logic [3:0] {
    CSS_LOCKED = 4'b0001,
    CSS_KEY1   = 4'b0010,
    CSS_KEY2   = 4'b0100,
    CSS_OPEN   = 4'b1000
  } css_lock_t;
endpackage

//--- testbench/css_clock_select_checker.sv
// Port checker of the clock source select block.
// Assumes a bind to css_clock_select and its single clock domain.
module css_clock_select_checker (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [11:0]       i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  input wire logic              i_tick_timer_control_bit2,
  input wire css_pkg::css_src_t o_bus_clock_source,
  input wire css_pkg::css_src_t o_tick_clock_source,
  input wire css_pkg::css_src_t o_uart_clock_source,
  input wire logic              o_protect_open
);
  import css_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_key(logic [7:0] k);
    i_wr && i_addr == OFS_WRITE_PROTECT && i_wdata[7:0] == k;
  endsequence
  property p_unlock;
    !o_protect_open ##0 s_key(UNLOCK_KEY1) ##1 s_key(UNLOCK_KEY2) ##1 s_key(UNLOCK_KEY3) |=> o_protect_open;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock keys did not open");
  property p_relock;
    o_protect_open && i_wr && i_addr == OFS_WRITE_PROTECT |=> !o_protect_open;
  endproperty
  a_relock: assert property (p_relock) else $error("protection stayed open");
  property p_tick_none;
    i_tick_timer_control_bit2 |=> o_tick_clock_source == CSS_SRC_NONE;
  endproperty
  a_tick_none: assert property (p_tick_none) else $error("tick source used while own bit set");
  property p_tick_legal;
    o_tick_clock_source inside {CSS_SRC_HXT, CSS_SRC_LXT, CSS_SRC_HXT_D2, CSS_SRC_BUS_D2, CSS_SRC_HIRC_D2, CSS_SRC_NONE};
  endproperty
  a_tick_legal: assert property (p_tick_legal) else $error("tick source out of set");
  property p_bus_legal;
    o_bus_clock_source inside {CSS_SRC_HXT, CSS_SRC_LXT, CSS_SRC_PLL, CSS_SRC_LIRC, CSS_SRC_HIRC, CSS_SRC_NONE};
  endproperty
  a_bus_legal: assert property (p_bus_legal) else $error("bus source out of set");
  property p_uart_legal;
    o_uart_clock_source inside {CSS_SRC_HXT, CSS_SRC_PLL, CSS_SRC_HIRC};
  endproperty
  a_uart_legal: assert property (p_uart_legal) else $error("uart source out of set");
  property p_rdata_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_rsvd_ones;
    i_rd && i_addr == OFS_PERIPH_SELECT |=> (o_rdata & PERIPH_RSVD_MASK) == PERIPH_RSVD_MASK;
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) else $error("reserved bits not one");
endmodule

//--- testbench/tb_clock_source_select.sv
// Self-checking bench of the clock source select block.
// Assumes a 125 MHz clock; all sources stable unless a test drops one.
module tb_clock_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_tick_timer_control_bit2 = 0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [4:0]  i_source_stable = 5'h1F;
  logic [2:0]  i_boot_oscillator_config = 3'h7;
  logic        o_protect_open, o_irq;
  css_src_t    o_bus_clock_source, o_tick_clock_source, o_pwm_pair_a_clock_source;
  css_src_t    o_pwm_pair_b_clock_source, o_uart_clock_source, o_timer_three_clock_source;
  int fail_count = 0;
  int total_checks = 0;
  css_clock_select dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_source_stable,
    .i_boot_oscillator_config, .i_tick_timer_control_bit2, .o_bus_clock_source, .o_tick_clock_source,
    .o_pwm_pair_a_clock_source, .o_pwm_pair_b_clock_source, .o_uart_clock_source,
    .o_timer_three_clock_source, .o_protect_open, .o_irq);
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // One idle edge after each strobe, so no strobe is assigned twice in one time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    cyc(1);
    i_rd <= 1'b0;
    chk(o_rdata, e);
    cyc(1);
  endtask
  // Keys back to back, strobe held high across them
  task automatic unlock();
    logic [7:0] k [3] = '{UNLOCK_KEY1, UNLOCK_KEY2, UNLOCK_KEY3};
    foreach (k[j]) begin
      i_wr <= 1'b1;
      i_addr <= OFS_WRITE_PROTECT;
      i_wdata <= {24'h0, k[j]};
      cyc(1);
    end
    i_wr <= 1'b0;
    cyc(1);
    chk(o_protect_open, 1'b1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset();
    chk(o_bus_clock_source, CSS_SRC_HIRC);
    rd(OFS_CORE_SELECT, 32'h3F);
    rd(OFS_PERIPH_SELECT, 32'hFFFFFFFF);
    rd(12'h0FC, 32'h0);
    cyc(8);
    chk(o_tick_clock_source, CSS_SRC_HIRC_D2);
    $display("test reset done");
  endtask
  task automatic t_locked();
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_CORE_SELECT, 32'h1A);
    rd(OFS_CORE_SELECT, 32'h3F);
    chk(o_irq, 1'b1);
    rd(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h1);
    chk(o_irq, 1'b0);
    wr(OFS_IRQ_CLEAR, 32'h2);
    rd(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h3);
    $display("test locked done");
  endtask
  task automatic t_switch();
    unlock();
    wr(OFS_CORE_SELECT, 32'h1A);
    cyc(2);
    chk(o_bus_clock_source, CSS_SRC_PLL);
    chk(o_tick_clock_source, CSS_SRC_BUS_D2);
    rd(OFS_CLOCK_STATUS, 32'h1F);
    wr(OFS_WRITE_PROTECT, 32'h0);
    chk(o_protect_open, 1'b0);
    $display("test switch done");
  endtask
  task automatic t_fail();
    i_source_stable <= 5'h1D;
    cyc(8);
    unlock();
    wr(OFS_CORE_SELECT, 32'h09);
    cyc(2);
    chk(o_bus_clock_source, CSS_SRC_PLL);
    rd(OFS_CLOCK_STATUS, 32'h9D);
    chk(o_irq, 1'b1);
    wr(OFS_CLOCK_STATUS, 32'h80);
    rd(OFS_CLOCK_STATUS, 32'h1D);
    i_source_stable <= 5'h1F;
    cyc(8);
    chk(o_bus_clock_source, CSS_SRC_LXT);
    chk(o_tick_clock_source, CSS_SRC_LXT);
    $display("test fail flag done");
  endtask
  // Last entry is unlisted on both fields and must hold the previous source
  task automatic t_codes();
    logic [2:0] bc [4] = '{3'h0, 3'h3, 3'h7, 3'h5};
    logic [2:0] tc [4] = '{3'h0, 3'h2, 3'h7, 3'h4};
    css_src_t be [4] = '{CSS_SRC_HXT, CSS_SRC_LIRC, CSS_SRC_HIRC, CSS_SRC_HIRC};
    css_src_t te [4] = '{CSS_SRC_HXT, CSS_SRC_HXT_D2, CSS_SRC_HIRC_D2, CSS_SRC_HIRC_D2};
    foreach (bc[i]) begin
      wr(OFS_CORE_SELECT, {26'h0, tc[i], bc[i]});
      cyc(2);
      chk(o_bus_clock_source, be[i]);
      chk(o_tick_clock_source, te[i]);
    end
    wr(OFS_WRITE_PROTECT, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h3);
    i_tick_timer_control_bit2 <= 1'b1;
    cyc(2);
    chk(o_tick_clock_source, CSS_SRC_NONE);
    i_tick_timer_control_bit2 <= 1'b0;
    cyc(2);
    chk(o_tick_clock_source, CSS_SRC_HIRC_D2);
    $display("test codes done");
  endtask
  task automatic t_periph();
    logic [31:0] w;
    logic [1:0] pw [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] ua [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [2:0] tm [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    css_src_t pe [4] = '{CSS_SRC_HXT, CSS_SRC_LXT, CSS_SRC_BUS, CSS_SRC_HIRC};
    css_src_t ue [4] = '{CSS_SRC_HXT, CSS_SRC_PLL, CSS_SRC_HIRC, CSS_SRC_HIRC};
    foreach (pw[i]) begin
      w = {pw[i], pw[3 - i], 2'h3, ua[i], 1'b1, tm[i], 20'hFFFFF};
      wr(OFS_PERIPH_SELECT, w);
      rd(OFS_PERIPH_SELECT, w);
      cyc(1);
      chk(o_pwm_pair_b_clock_source, pe[i]);
      chk(o_pwm_pair_a_clock_source, pe[3 - i]);
      chk(o_uart_clock_source, ue[i]);
      chk(o_timer_three_clock_source, pe[i]);
    end
    $display("test peripheral done");
  endtask
  // Mid-run reset with the crystal strap; the bus source must not wait for sync
  task automatic t_strap();
    i_boot_oscillator_config <= 3'h0;
    i_rst <= 1'b1;
    cyc(2);
    i_rst <= 1'b0;
    chk(o_bus_clock_source, CSS_SRC_HXT);
    chk(o_protect_open, 1'b0);
    chk(o_irq, 1'b0);
    rd(OFS_CORE_SELECT, 32'h38);
    rd(OFS_PERIPH_SELECT, 32'hFFFFFFFF);
    cyc(8);
    chk(o_tick_clock_source, CSS_SRC_HIRC_D2);
    chk(o_bus_clock_source, CSS_SRC_HXT);
    $display("test strap done");
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    t_reset();
    t_locked();
    t_switch();
    t_fail();
    t_codes();
    t_periph();
    t_strap();
    test_done();
  end
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule
bind css_clock_select css_clock_select_checker u_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_tick_timer_control_bit2, .o_bus_clock_source, .o_tick_clock_source, .o_uart_clock_source,
  .o_protect_open);
